// file: ccd_defs.svh
// Constants for the clear-and-call instruction decoder.
// Assumes 14-bit instruction words and a 13-bit program counter.
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH
`define CCD_CLEAR_FILE_REG_OP_MASK   14'h3F80
`define CCD_CLEAR_FILE_REG_OP_MATCH  14'h0180
`define CCD_CALL_MASK   14'h3800
`define CCD_CALL_MATCH  14'h2000
`define CCD_CLEAR_ACCUMULATOR_OP_CODE   14'h0103
`define CCD_WDTR_CODE   14'h0064
`define CCD_ZERO_BYTE   8'h00
`define CCD_PC_RESET    13'h0000
`define CCD_PC_STEP     13'h0001
`define CCD_LATCH_HI    4
`define CCD_LATCH_LO    3
`define CCD_IMM_HI      10
`define CCD_IMM_LO      0
`define CCD_ADDR_HI     6
`define CCD_ADDR_LO     0
`endif

// file: ccd_pkg.sv
// Types shared by the clear-and-call decoder files.
// Assumes ccd_defs.svh is on the include path.
package ccd_pkg;
  typedef enum logic [2:0] {
    CCD_OP_NONE,
    CCD_OP_CLEAR_FILE_REG_OP,
    CCD_OP_CALL,
    CCD_OP_CLEAR_ACCUMULATOR_OP,
    CCD_OP_WDTR
  } ccd_op_e;

  typedef enum logic {
    CCD_CALL_IDLE,
    CCD_CALL_SLOT
  } ccd_call_e;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] data;
  } ccd_file_wr_s;

  typedef struct packed {
    logic        valid;
    logic [12:0] addr;
  } ccd_push_s;
endpackage : ccd_pkg

// file: ccd_opdec.sv
// Combinational opcode classifier for the clear-and-call decoder.
// Assumes a full 14-bit instruction word at its input.
`timescale 1ns/1ps
`include "ccd_defs.svh"
module ccd_opdec
  import ccd_pkg::*;
(
  input  wire logic [13:0] instr,
  output ccd_op_e          op
);
  always_comb begin
    if ((instr & `CCD_CLEAR_FILE_REG_OP_MASK) == `CCD_CLEAR_FILE_REG_OP_MATCH) begin
      op = CCD_OP_CLEAR_FILE_REG_OP;
    end else if ((instr & `CCD_CALL_MASK) == `CCD_CALL_MATCH) begin
      op = CCD_OP_CALL;
    end else if (instr == `CCD_CLEAR_ACCUMULATOR_OP_CODE) begin
      op = CCD_OP_CLEAR_ACCUMULATOR_OP;
    end else if (instr == `CCD_WDTR_CODE) begin
      op = CCD_OP_WDTR;
    end else begin
      op = CCD_OP_NONE;
    end
  end
endmodule : ccd_opdec

// file: ccd_exec.sv
// Execute stage for clear-file, call, clear-accumulator and watchdog refresh.
// Assumes one instr_en pulse per instruction cycle; the stack, file and
// watchdog live outside and act on the one-cycle strobes given here.
`timescale 1ns/1ps
`include "ccd_defs.svh"
module ccd_exec
  import ccd_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         instr_en,
  input  wire logic [13:0]  instr,
  input  wire logic [12:0]  pc_cur,
  input  wire logic [7:0]   pc_upper_latch,
  output ccd_file_wr_s      file_wr_q,
  output logic              accum_clr_q,
  output logic              zero_set_q,
  output ccd_push_s         stack_top_q,
  output logic              pc_load_q,
  output logic [12:0]       pc_next_q,
  output logic              flush_q,
  output logic              watchdog_counter_clr_q,
  output logic              timeout_flag_n_set_q,
  output logic              powerdown_flag_n_set_q,
  output logic              busy_q
);
  ccd_op_e     op;
  ccd_call_e   call_state_q;
  ccd_call_e   call_state_d;

  logic        go;
  logic        hit_clear_file_reg_op;
  logic        hit_call;
  logic        hit_clear_accumulator_op;
  logic        hit_wdtr;
  logic        take_clear_file_reg_op;
  logic        take_call;
  logic        take_clear_accumulator_op;
  logic        take_wdtr;

  logic [12:0] ret_addr;
  logic [12:0] call_target;
  logic [6:0]  file_addr;

  ccd_opdec u_opdec (
    .instr (instr),
    .op    (op)
  );

  // One flag per class keeps the strobe logic below free of enum compares
  always_comb begin
    hit_clear_file_reg_op = 1'b0;
    hit_call = 1'b0;
    hit_clear_accumulator_op = 1'b0;
    hit_wdtr = 1'b0;
    case (op)
      CCD_OP_CLEAR_FILE_REG_OP: begin
        hit_clear_file_reg_op = 1'b1;
      end
      CCD_OP_CALL: begin
        hit_call = 1'b1;
      end
      CCD_OP_CLEAR_ACCUMULATOR_OP: begin
        hit_clear_accumulator_op = 1'b1;
      end
      CCD_OP_WDTR: begin
        hit_wdtr = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Call sequencer: the slot after a call carries the prefetched word,
  // which is thrown away however late its enable arrives
  always_comb begin
    call_state_d = call_state_q;
    case (call_state_q)
      CCD_CALL_IDLE: begin
        if (instr_en && hit_call) begin
          call_state_d = CCD_CALL_SLOT;
        end
      end
      CCD_CALL_SLOT: begin
        if (instr_en) begin
          call_state_d = CCD_CALL_IDLE;
        end
      end
      default: begin
        call_state_d = CCD_CALL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      call_state_q <= CCD_CALL_IDLE;
    end else begin
      call_state_q <= call_state_d;
    end
  end

  // Nothing is taken in the discarded slot
  assign go        = instr_en && (call_state_q == CCD_CALL_IDLE);
  assign take_clear_file_reg_op = go && hit_clear_file_reg_op;
  assign take_call = go && hit_call;
  assign take_clear_accumulator_op = go && hit_clear_accumulator_op;
  assign take_wdtr = go && hit_wdtr;

  // Return address wraps within the 13-bit program space
  assign ret_addr    = pc_cur + `CCD_PC_STEP;
  assign call_target = {pc_upper_latch[`CCD_LATCH_HI:`CCD_LATCH_LO],
                        instr[`CCD_IMM_HI:`CCD_IMM_LO]};
  assign file_addr   = instr[`CCD_ADDR_HI:`CCD_ADDR_LO];

  // Busy holds through the slot until the next enable, even a late one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (instr_en) begin
      busy_q <= take_call;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= take_call;
    end
  end

  // Address follows instr every cycle and data is always zero; only valid qualifies them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      file_wr_q <= '0;
    end else begin
      file_wr_q.valid <= take_clear_file_reg_op;
      file_wr_q.addr  <= file_addr;
      file_wr_q.data  <= `CCD_ZERO_BYTE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      accum_clr_q <= 1'b0;
    end else begin
      accum_clr_q <= take_clear_accumulator_op;
    end
  end

  // Zero flag is only ever set here; its other writers live outside
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      zero_set_q <= 1'b0;
    end else begin
      zero_set_q <= take_clear_accumulator_op || take_clear_file_reg_op;
    end
  end

  // Push address is held after the strobe; only valid marks a push
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stack_top_q <= '0;
    end else begin
      stack_top_q.valid <= take_call;
      if (take_call) begin
        stack_top_q.addr <= ret_addr;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= take_call;
    end
  end

  // Target holds between calls so the counter logic may reload it late
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc_next_q <= `CCD_PC_RESET;
    end else if (take_call) begin
      pc_next_q <= call_target;
    end
  end

  // Three separate strobes: counter, timeout flag and power-down flag sit in other logic
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      watchdog_counter_clr_q <= 1'b0;
    end else begin
      watchdog_counter_clr_q <= take_wdtr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timeout_flag_n_set_q <= 1'b0;
    end else begin
      timeout_flag_n_set_q <= take_wdtr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      powerdown_flag_n_set_q <= 1'b0;
    end else begin
      powerdown_flag_n_set_q <= take_wdtr;
    end
  end
endmodule : ccd_exec

// file: ccd_exec_chk.sv
// Port-level checks on the clear-and-call execute stage.
// Assumes ccd_exec ports; bound to every instance by name.
`timescale 1ns/1ps
module ccd_chk
  import ccd_pkg::*;
(
  input logic         clk_sys,
  input logic         reset,
  input logic         instr_en,
  input logic [13:0]  instr,
  input logic [12:0]  pc_cur,
  input logic [7:0]   pc_upper_latch,
  input ccd_file_wr_s file_wr_q,
  input logic         accum_clr_q,
  input logic         zero_set_q,
  input ccd_push_s    stack_top_q,
  input logic         pc_load_q,
  input logic [12:0]  pc_next_q,
  input logic         flush_q,
  input logic         watchdog_counter_clr_q,
  input logic         timeout_flag_n_set_q,
  input logic         powerdown_flag_n_set_q,
  input logic         busy_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire t = instr_en && !busy_q;
  sequence call_s;
    t && instr[13:11] == 3'h4;
  endsequence
  clr_file_a: assert property (t && instr[13:7] == 7'h03 |=> zero_set_q
    && file_wr_q == {1'b1, $past(instr[6:0]), 8'h00}) else $error("bad clear");
  push_a: assert property (call_s |=> stack_top_q == {1'b1, $past(pc_cur) + 13'h1})
    else $error("bad push");
  low_target_a: assert property (call_s |=> pc_load_q
    && pc_next_q[10:0] == $past(instr[10:0])) else $error("bad target");
  high_target_a: assert property (call_s |=>
    pc_next_q[12:11] == $past(pc_upper_latch[4:3])) else $error("bad page");
  two_cycle_a: assert property (call_s |=> flush_q && busy_q ##1 !pc_load_q)
    else $error("bad call timing");
  slot_ignored_a: assert property (busy_q && instr_en |=>
    !zero_set_q && !pc_load_q && !file_wr_q.valid) else $error("slot used");
  clr_acc_a: assert property (t && instr == 14'h0103 |=> accum_clr_q && zero_set_q)
    else $error("bad accumulator clear");
  wdt_clear_a: assert property (t && instr == 14'h0064 |=> watchdog_counter_clr_q
    && timeout_flag_n_set_q && powerdown_flag_n_set_q) else $error("bad refresh");
  one_cycle_a: assert property (t && instr[13:11] != 3'h4 |=> !busy_q && !flush_q)
    else $error("stall");
endmodule : ccd_chk
bind ccd_exec ccd_chk i_ccd_chk (
  .clk_sys                (clk_sys),
  .reset                  (reset),
  .instr_en               (instr_en),
  .instr                  (instr),
  .pc_cur                 (pc_cur),
  .pc_upper_latch         (pc_upper_latch),
  .file_wr_q              (file_wr_q),
  .accum_clr_q            (accum_clr_q),
  .zero_set_q             (zero_set_q),
  .stack_top_q            (stack_top_q),
  .pc_load_q              (pc_load_q),
  .pc_next_q              (pc_next_q),
  .flush_q                (flush_q),
  .watchdog_counter_clr_q (watchdog_counter_clr_q),
  .timeout_flag_n_set_q   (timeout_flag_n_set_q),
  .powerdown_flag_n_set_q (powerdown_flag_n_set_q),
  .busy_q                 (busy_q)
);

// file: clear_and_call_instructions_test.sv
// Self-checking bench for ccd_exec: directed then random words.
// Assumes the checker file is compiled with it.
`timescale 1ns/1ps
module clear_and_call_instructions_test
  import ccd_pkg::*;
;
  logic         clk_sys = 1'h0, reset = 1'h1, instr_en = 1'h0, skip = 1'h0;
  logic [13:0]  instr = '0;
  logic [12:0]  pc_cur = '0, pc_next_q;
  logic [7:0]   pc_upper_latch = '0;
  ccd_file_wr_s file_wr_q;
  ccd_push_s    stack_top_q;
  logic         accum_clr_q, zero_set_q, pc_load_q, flush_q, busy_q;
  logic         watchdog_counter_clr_q, timeout_flag_n_set_q, powerdown_flag_n_set_q;
  logic [50:0]  q[$], got;
  logic [31:0]  r, k;
  int           fail_count = 0, cmp_count = 0, cyc = 0;
  wire [8:0] o = {file_wr_q.valid, accum_clr_q, zero_set_q, stack_top_q.valid, pc_load_q,
    flush_q, watchdog_counter_clr_q, timeout_flag_n_set_q, powerdown_flag_n_set_q};
  ccd_exec i_ccd_exec (
    .clk_sys                (clk_sys),
    .reset                  (reset),
    .instr_en               (instr_en),
    .instr                  (instr),
    .pc_cur                 (pc_cur),
    .pc_upper_latch         (pc_upper_latch),
    .file_wr_q              (file_wr_q),
    .accum_clr_q            (accum_clr_q),
    .zero_set_q             (zero_set_q),
    .stack_top_q            (stack_top_q),
    .pc_load_q              (pc_load_q),
    .pc_next_q              (pc_next_q),
    .flush_q                (flush_q),
    .watchdog_counter_clr_q (watchdog_counter_clr_q),
    .timeout_flag_n_set_q   (timeout_flag_n_set_q),
    .powerdown_flag_n_set_q (powerdown_flag_n_set_q),
    .busy_q                 (busy_q)
  );
  always #4 clk_sys = ~clk_sys;
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Notes go in only for taken words; the slot after a call stays silent
  task op(input logic [13:0] w);
    @(posedge clk_sys) #1;
    k = $urandom;
    instr_en = 1;
    instr = w;
    pc_cur = k[12:0];
    pc_upper_latch = k[20:13];
    if (skip) skip = 0;
    else if (w[13:11] == 3'h4) begin
      skip = 1;
      q.push_back({10'h238, 15'h0, pc_cur + 13'h1, pc_upper_latch[4:3], w[10:0]});
    end else if (w[13:7] == 7'h03) q.push_back({10'h140, w[6:0], 34'h0});
    else if (w == 14'h0103) q.push_back({10'h0c0, 41'h0});
    else if (w == 14'h0064) q.push_back({10'h007, 41'h0});
  endtask : op
  always @(posedge clk_sys) begin
    #1 cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_sim;
    end
    if ((|o) !== 1'b0) begin
      cmp_count++;
      got = {busy_q, o, file_wr_q[14:0] & {15{o[8]}},
        {stack_top_q.addr, pc_next_q} & {26{o[5]}}};
      if (q.size() == 0 || q.pop_front() !== got) begin
        fail_count++;
        $display("unexpected %0t result %h", $time, got);
      end
    end
  end
  initial begin
    r = $urandom(32'h4bc2_fb7e);
    repeat (20) @(posedge clk_sys);
    #1 reset = 0;
    op(14'h0064);
    op(14'h0103);
    op(14'h01ff);
    op(14'h27ff);
    op(14'h0180);
    op(14'h2000);
    op(14'h2000);
    op(14'h0180);
    $display("directed done");
    repeat (300) begin
      r = $urandom;
      op(r[2] ? r[13:0] : r[1] ? (r[0] ? 14'h0103 : 14'h0064)
        : r[0] ? 14'h2000 | r[16:6] : 14'h0180 | r[16:10]);
    end
    @(posedge clk_sys) #1 instr_en = 0;
    repeat (3) @(posedge clk_sys);
    #2;
    if (q.size() != 0) begin
      fail_count++;
      $display("unexpected %0t missing results", $time);
    end
    $display("random done");
    end_sim;
  end
endmodule : clear_and_call_instructions_test
